// ===== logic/pmbpw_cmd.sv
// command interpreter: page select, page-plus packets, write lock,
// target/global/rail address decode and rail read contention check
// assumes a bus engine delivering one decoded transaction per req_valid
//
// Summary of operation
// R01: page 0x00 selects channel 0, 0x01 channel 1 for paged commands
// R02: page 0xff sends paged writes to both channels at once
// R03: page 0xff reads return channel 0 data
// R04: page-plus write runs the target command on the given page
// R05: page-plus read returns the target data of the given page
// R06: page-plus packets never change the stored page
// R07: page byte ignored when the target command is not paged
// R08: page-plus write accepted only if the lock level allows it
// R09: nested page-plus packet is refused and raises a comm fault
// R10: lock 0x80 allows only lock, page, unlock and store writes
// R11: lock 0x40 also allows peak clear, operation, clear faults
// R12: lock 0x20 also allows on/off config and vout command
// R13: status fault bits stay write-one-clear under partial locks and pin
// R14: lock 0x00 allows all writes; reserved low lock bits must be 0
// R15: protect pin overrides lock, allowing page, operation, peaks, unlock, clear
// R16: target address is 7 bit from code 0xe6, default 0x4f
// R17: target address 0x80 disables the individual address
// R18: global addresses 0x5a and 0x5b always answer
// R19: straps still set address parts even if strap use is off
// R20: open strap takes the stored address bits instead
// R21: paged rail address 0xfa reaches its channel; 0x80 disables it
// R22: rail read mismatch on the bus sets a comm fault
// R23: blocked writes leave the target alone and raise a comm fault
`timescale 1ns/1ns
`include "pmbpw_map.svh"
module pmbpw_cmd (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    req_valid,
    input  wire pmbpw_pkg::pmbpw_req_type req,
    input  wire logic [1:0][7:0]         ext_rdata,
    input  wire logic                    wp_pin,
    input  wire logic                    strap_high_open,
    input  wire logic [2:0]              strap_high_val,
    input  wire logic                    strap_low_open,
    input  wire logic [3:0]              strap_low_val,
    input  wire logic                    obs_valid,
    input  wire logic [7:0]              obs_byte,
    output logic                         rsp_valid,
    output pmbpw_pkg::pmbpw_rsp_type     rsp,
    output logic                         fwd_valid,
    output pmbpw_pkg::pmbpw_fwd_type     fwd,
    output logic                         comm_fault,
    output logic [7:0]                   page_sel,
    output logic [1:0][7:0]              channel_config_bits,
    output logic [7:0]                   global_config_bits
);
    import pmbpw_pkg::*;

    // ----------------------------------------
    // stored registers
    // ----------------------------------------
    logic [7:0]      page_q;
    logic [7:0]      lock_q;
    logic [1:0][7:0] ccfg_q;
    logic [7:0]      gcfg_q;
    logic [7:0]      taddr_q;
    logic [1:0][7:0] raddr_q;
    logic [7:0]      rail_data_q;
    pmbpw_state_type state_q;

    // ----------------------------------------
    // command classes
    // ----------------------------------------
    function automatic logic is_status(input logic [7:0] c);
        return (c >= `PMBPW_STAT_FIRST) && (c <= `PMBPW_STAT_LAST);
    endfunction

    function automatic logic is_paged(input logic [7:0] c);
        return (c == `PMBPW_OPERATION) || (c == `PMBPW_ON_OFF_CFG) ||
               (c == `PMBPW_CLR_FAULTS) || (c == `PMBPW_VOUT_CMD) ||
               (c == `PMBPW_CHAN_CFG) || (c == `PMBPW_RAIL_ADDR) ||
               (c == `PMBPW_PEAK_CLEAR) || is_status(c);
    endfunction

    function automatic logic wr_allowed(input logic [7:0] c, input logic [7:0] lvl,
                                        input logic pin);
        logic l80;
        logic l40;
        logic l20;
        l80 = (c == `PMBPW_WR_LOCK) || (c == `PMBPW_PAGE) ||
              (c == `PMBPW_NV_UNLOCK) || (c == `PMBPW_STORE_ALL); // see R10
        l40 = l80 || (c == `PMBPW_PEAK_CLEAR) || (c == `PMBPW_OPERATION) ||
              (c == `PMBPW_CLR_FAULTS) || is_status(c); // see R11, R13
        l20 = l40 || (c == `PMBPW_ON_OFF_CFG) || (c == `PMBPW_VOUT_CMD); // see R12
        if (pin) begin
            // pin list is not a superset of any level: lock and store are shut
            return (c == `PMBPW_PAGE) || (c == `PMBPW_OPERATION) ||
                   (c == `PMBPW_PEAK_CLEAR) || (c == `PMBPW_NV_UNLOCK) ||
                   (c == `PMBPW_CLR_FAULTS) || is_status(c); // see R15, R13
        end
        unique case (lvl)
            `PMBPW_LOCK_ALL:  return l80;
            `PMBPW_LOCK_OPER: return l40;
            `PMBPW_LOCK_CTRL: return l20;
            default:          return 1'b1; // see R14
        endcase
    endfunction

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic [6:0] dev_addr;
    logic       hit_dev;
    logic       hit_glob;
    logic [1:0] hit_rail;
    logic       hit;
    logic       rail_only;

    always_comb begin
        // open strap falls back to the stored bits
        dev_addr[6:4] = strap_high_open ? taddr_q[6:4] : strap_high_val; // see R19, R20
        dev_addr[3:0] = strap_low_open  ? taddr_q[3:0] : strap_low_val;  // see R19, R20
    end

    assign hit_dev  = (taddr_q != `PMBPW_ADDR_OFF) && (req.addr == dev_addr); // see R16, R17
    assign hit_glob = (req.addr == `PMBPW_GLOB_A) || (req.addr == `PMBPW_GLOB_B); // see R18
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            hit_rail[i] = (raddr_q[i] != `PMBPW_ADDR_OFF) &&
                          (req.addr == raddr_q[i][6:0]); // see R21
        end
    end
    assign hit       = hit_dev || hit_glob || (hit_rail != 2'h0);
    assign rail_only = !hit_dev && !hit_glob && (hit_rail != 2'h0);

    // ----------------------------------------
    // packet decision
    // ----------------------------------------
    logic       pp;
    logic       is_wr;
    logic [7:0] pg;
    logic       pg_ok;
    logic [1:0] cmask;
    logic       rch;
    logic       nest;
    logic       bad_val;
    logic       blocked;
    logic       refuse;
    logic       local_cmd;
    logic [7:0] rd_local;
    logic       take;

    assign pp    = (req.kind == PMBPW_PPW) || (req.kind == PMBPW_PPR);
    assign is_wr = (req.kind == PMBPW_WR) || (req.kind == PMBPW_PPW);
    assign pg    = pp ? req.page : page_q; // see R04, R05
    assign pg_ok = (pg == `PMBPW_PG_CH0) || (pg == `PMBPW_PG_CH1) || (pg == `PMBPW_PG_ALL);

    always_comb begin
        if (rail_only) begin
            cmask = hit_rail; // see R21
        end else if (pg == `PMBPW_PG_CH1) begin
            cmask = 2'h2;
        end else if (pg == `PMBPW_PG_ALL) begin
            cmask = 2'h3; // see R02
        end else begin
            cmask = 2'h1; // see R01
        end
    end
    // all-channel reads come from channel 0
    assign rch = !cmask[0]; // see R03

    // nesting, and a page-plus aimed at the page itself, would break the packet
    assign nest = pp && ((req.code == `PMBPW_PP_WRITE) || (req.code == `PMBPW_PP_READ) ||
                         (req.code == `PMBPW_PAGE)); // see R09, R06
    always_comb begin
        bad_val = 1'b0;
        if (req.code == `PMBPW_PAGE) begin
            bad_val = !((req.data == `PMBPW_PG_CH0) || (req.data == `PMBPW_PG_CH1) ||
                        (req.data == `PMBPW_PG_ALL));
        end else if (req.code == `PMBPW_WR_LOCK) begin
            // reserved low bits must stay clear
            bad_val = !((req.data == `PMBPW_LOCK_NONE) || (req.data == `PMBPW_LOCK_CTRL) ||
                        (req.data == `PMBPW_LOCK_OPER) || (req.data == `PMBPW_LOCK_ALL)); // see R14
        end
    end
    assign blocked = !wr_allowed(req.code, lock_q, wp_pin); // see R08, R23
    // page byte only matters for paged targets
    assign refuse  = nest || (pp && !rail_only && is_paged(req.code) && !pg_ok) ||
                     (is_wr && (blocked || bad_val)); // see R07, R23
    assign take    = req_valid && hit && !refuse;

    always_comb begin
        local_cmd = 1'b1;
        rd_local  = 8'h00;
        unique case (req.code)
            `PMBPW_PAGE:      rd_local = page_q;
            `PMBPW_WR_LOCK:   rd_local = lock_q;
            `PMBPW_CHAN_CFG:  rd_local = ccfg_q[rch];
            `PMBPW_GLOB_CFG:  rd_local = gcfg_q;
            `PMBPW_TGT_ADDR:  rd_local = taddr_q;
            `PMBPW_RAIL_ADDR: rd_local = raddr_q[rch];
            default:          local_cmd = 1'b0;
        endcase
    end

    // ----------------------------------------
    // stored registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_q <= `PMBPW_PG_CH0;
        end else if (take && is_wr && !pp && req.code == `PMBPW_PAGE) begin
            page_q <= req.data; // see R01, R06
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= `PMBPW_LOCK_NONE;
        end else if (take && is_wr && req.code == `PMBPW_WR_LOCK) begin
            lock_q <= req.data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gcfg_q  <= `PMBPW_RST_GLCFG;
            taddr_q <= `PMBPW_RST_TADDR; // see R16
        end else if (take && is_wr) begin
            if (req.code == `PMBPW_GLOB_CFG) begin
                gcfg_q <= req.data;
            end
            if (req.code == `PMBPW_TGT_ADDR) begin
                taddr_q <= req.data; // see R17
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ccfg_q  <= {2{`PMBPW_RST_CHCFG}};
            raddr_q <= {2{`PMBPW_RST_RADDR}}; // see R21
        end else if (take && is_wr) begin
            for (int i = 0; i < 2; i++) begin
                if (cmask[i] && req.code == `PMBPW_CHAN_CFG) begin
                    ccfg_q[i] <= req.data; // see R02, R04
                end
                if (cmask[i] && req.code == `PMBPW_RAIL_ADDR) begin
                    raddr_q[i] <= req.data;
                end
            end
        end
    end

    // ----------------------------------------
    // answers and forwarded writes
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp       <= '0;
        end else begin
            rsp_valid <= req_valid && hit;
            if (req_valid && hit) begin
                rsp.ack   <= !refuse; // see R09
                rsp.rdata <= (is_wr || refuse) ? 8'h00 :
                             local_cmd ? rd_local : ext_rdata[rch]; // see R03, R05
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_valid <= 1'b0;
            fwd       <= '0;
        end else begin
            fwd_valid <= take && is_wr && !local_cmd; // see R04, R23
            if (take && is_wr && !local_cmd) begin
                fwd.code <= req.code;
                fwd.data <= req.data;
                // zero channel mask marks a non-paged command
                fwd.chan <= is_paged(req.code) ? cmask : 2'h0; // see R07
                fwd.w1c  <= is_status(req.code); // see R13
            end
        end
    end

    // ----------------------------------------
    // rail read contention
    // ----------------------------------------
    // the observed byte is what really crossed the bus, so another rail member
    // driving a different value shows up here
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= PMBPW_IDLE;
            rail_data_q <= 8'h00;
        end else begin
            unique case (state_q)
                PMBPW_IDLE: begin
                    if (take && !is_wr && rail_only) begin
                        state_q     <= PMBPW_RAIL;
                        rail_data_q <= local_cmd ? rd_local : ext_rdata[rch];
                    end
                end
                PMBPW_RAIL: begin
                    if (obs_valid || req_valid) begin
                        state_q <= PMBPW_IDLE;
                    end
                end
                default: state_q <= PMBPW_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            comm_fault <= 1'b0;
        end else begin
            comm_fault <= (req_valid && hit && refuse) ||
                          (state_q == PMBPW_RAIL && obs_valid &&
                           obs_byte != rail_data_q); // see R22, R23
        end
    end

    assign page_sel            = page_q;
    assign channel_config_bits = ccfg_q;
    assign global_config_bits  = gcfg_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic dev_wr;
    assign dev_wr = req_valid && hit_dev && req.kind == PMBPW_WR;

    sequence s_rail_read;
        take && !is_wr && rail_only;
    endsequence
    sequence s_mismatch;
        obs_valid && obs_byte != rail_data_q;
    endsequence

    property p_page_ch1;
        dev_wr && req.code == `PMBPW_PAGE && req.data == `PMBPW_PG_CH1 && !wp_pin
        |=> page_q == `PMBPW_PG_CH1;
    endproperty
    a_page_ch1: assert property (p_page_ch1) else $error("page 1 not stored"); // see R01

    property p_all_write;
        take && !pp && page_q == `PMBPW_PG_ALL && is_wr && !local_cmd &&
        !rail_only && is_paged(req.code)
        |=> fwd_valid && fwd.chan == 2'h3;
    endproperty
    a_all_write: assert property (p_all_write) else $error("all-page write lost"); // see R02

    property p_all_read;
        req_valid && hit_dev && req.kind == PMBPW_RD && page_q == `PMBPW_PG_ALL &&
        !local_cmd
        |=> rsp_valid && rsp.rdata == $past(ext_rdata[0]);
    endproperty
    a_all_read: assert property (p_all_read) else $error("all-page read not ch0"); // see R03

    property p_pp_keep;
        req_valid && pp |=> page_q == $past(page_q);
    endproperty
    a_pp_keep: assert property (p_pp_keep) else $error("page changed by page-plus"); // see R06

    property p_nest;
        req_valid && hit && pp && req.code == `PMBPW_PP_WRITE
        |=> rsp_valid && !rsp.ack && comm_fault;
    endproperty
    a_nest: assert property (p_nest) else $error("nested page-plus accepted"); // see R09

    property p_lock_all;
        req_valid && hit && is_wr && !wp_pin && lock_q == `PMBPW_LOCK_ALL &&
        req.code == `PMBPW_OPERATION
        |=> !fwd_valid && comm_fault && !rsp.ack;
    endproperty
    a_lock_all: assert property (p_lock_all) else $error("write passed full lock"); // see R10

    property p_pin;
        req_valid && hit && is_wr && wp_pin && req.code == `PMBPW_ON_OFF_CFG
        |=> comm_fault && !fwd_valid;
    endproperty
    a_pin: assert property (p_pin) else $error("write passed protect pin"); // see R15

    property p_w1c;
        req_valid && hit && is_wr && wp_pin && is_status(req.code) && !refuse
        |=> fwd_valid && fwd.w1c;
    endproperty
    a_w1c: assert property (p_w1c) else $error("status clear blocked"); // see R13

    property p_global;
        req_valid && (req.addr == `PMBPW_GLOB_A || req.addr == `PMBPW_GLOB_B)
        |=> rsp_valid;
    endproperty
    a_global: assert property (p_global) else $error("global address ignored"); // see R18

    property p_rail;
        s_rail_read ##1 !(obs_valid || req_valid) ##1 s_mismatch |=> comm_fault;
    endproperty
    a_rail: assert property (p_rail) else $error("rail contention missed"); // see R22
endmodule

// ===== logic/pmbpw_map.svh
// command codes, reset values and fixed addresses of the pmbus page/address/protect block
// assumes nothing; definitions only
`ifndef PMBPW_MAP_SVH
`define PMBPW_MAP_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define PMBPW_PAGE        8'h00
`define PMBPW_OPERATION   8'h01
`define PMBPW_ON_OFF_CFG  8'h02
`define PMBPW_CLR_FAULTS  8'h03
`define PMBPW_PP_WRITE    8'h05
`define PMBPW_PP_READ     8'h06
`define PMBPW_WR_LOCK     8'h10
`define PMBPW_STORE_ALL   8'h15
`define PMBPW_VOUT_CMD    8'h21
`define PMBPW_STAT_FIRST  8'h78
`define PMBPW_STAT_LAST   8'h7f
`define PMBPW_NV_UNLOCK   8'hbd
`define PMBPW_PEAK_CLEAR  8'he3
`define PMBPW_CHAN_CFG    8'hd0
`define PMBPW_GLOB_CFG    8'hd1
`define PMBPW_TGT_ADDR    8'he6
`define PMBPW_RAIL_ADDR   8'hfa
// ----------------------------------------
// values
// ----------------------------------------
`define PMBPW_PG_CH0      8'h00
`define PMBPW_PG_CH1      8'h01
`define PMBPW_PG_ALL      8'hff
`define PMBPW_LOCK_NONE   8'h00
`define PMBPW_LOCK_CTRL   8'h20
`define PMBPW_LOCK_OPER   8'h40
`define PMBPW_LOCK_ALL    8'h80
`define PMBPW_ADDR_OFF    8'h80
`define PMBPW_GLOB_A      7'h5a
`define PMBPW_GLOB_B      7'h5b
`define PMBPW_RST_CHCFG   8'h1d
`define PMBPW_RST_GLCFG   8'h21
`define PMBPW_RST_TADDR   8'h4f
`define PMBPW_RST_RADDR   8'h80
`endif

// ===== logic/pmbpw_pkg.sv
// types shared by the pmbus page/address/protect block
// assumes a bus engine that decodes whole transactions
package pmbpw_pkg;
    typedef enum logic [1:0] {
        PMBPW_WR  = 2'h0,
        PMBPW_RD  = 2'h1,
        PMBPW_PPW = 2'h2,
        PMBPW_PPR = 2'h3
    } pmbpw_kind_type;
    typedef struct packed {
        logic [6:0]     addr;
        pmbpw_kind_type kind;
        logic [7:0]     code;
        logic [7:0]     page;
        logic [7:0]     data;
    } pmbpw_req_type;
    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
    } pmbpw_rsp_type;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
        logic [1:0] chan;
        logic       w1c;
    } pmbpw_fwd_type;
    typedef enum logic [1:0] {
        PMBPW_IDLE = 2'b01,
        PMBPW_RAIL = 2'b10
    } pmbpw_state_type;
endpackage

// ===== verification/pmbpw_host_model.sv
// bus host stand-in: hands one decoded transaction to the block per call
// assumes the bench calls its tasks only after reset has been released
`timescale 1ns/1ns
module pmbpw_host_model (
    input  wire logic                sys_clk,
    output pmbpw_pkg::pmbpw_req_type req,
    output logic                     req_valid,
    output logic                     obs_valid,
    output logic [7:0]               obs_byte
);
    import pmbpw_pkg::*;
    initial begin
        req_valid = 1'b0;
        obs_valid = 1'b0;
        req = '0;
        obs_byte = 8'h00;
    end
    // ----------------------------------------
    // packets
    // ----------------------------------------
    // page-plus kinds carry page, target code and data in one packet
    task automatic send(input logic [6:0] a, input pmbpw_kind_type k, input logic [7:0] c,
                        input logic [7:0] p, input logic [7:0] d);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{addr: a, kind: k, code: c, page: p, data: d};
        @(posedge sys_clk);
        req_valid <= 1'b0;
        // released fields flip so a stale packet never looks valid
        req <= ~req;
    endtask
    // byte seen on the wire for the last rail read
    task automatic observe(input logic [7:0] b);
        @(posedge sys_clk);
        obs_valid <= 1'b1;
        obs_byte <= b;
        @(posedge sys_clk);
        obs_valid <= 1'b0;
        obs_byte <= ~b;
    endtask
endmodule

// ===== verification/pmbus_page_addr_write_protect_tb_top.sv
// self-checking bench for the page, protect and address command block
// assumes the host model drives the transaction port
`timescale 1ns/1ns
module pmbus_page_addr_write_protect_tb_top;
    import pmbpw_pkg::*;
    logic            sys_clk, rst_n, wp_pin, req_valid, obs_valid, rsp_valid, fwd_valid;
    logic            strap_high_open, strap_low_open, comm_fault;
    logic [2:0]      strap_high_val;
    logic [3:0]      strap_low_val, seen, sv;
    logic [7:0]      obs_byte, page_sel, global_config_bits, rd, d, d2, glob, dat;
    logic [1:0][7:0] ext_rdata, channel_config_bits;
    pmbpw_req_type   req;
    pmbpw_rsp_type   rsp;
    pmbpw_fwd_type   fwd;
    int              err_count = 0;
    int              checked = 0;
    logic [7:0] rst_code [6] = '{8'h00, 8'h10, 8'hd0, 8'hd1, 8'he6, 8'hfa};
    logic [7:0] rst_val [6] = '{8'h00, 8'h00, 8'h1d, 8'h21, 8'h4f, 8'h80};
    logic [7:0] lvl [5] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h00};
    logic [7:0] codes [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h15, 8'h21, 8'h78,
                               8'hbd, 8'hd1, 8'he3};

    pmbpw_host_model host (.sys_clk(sys_clk), .req(req), .req_valid(req_valid),
        .obs_valid(obs_valid), .obs_byte(obs_byte));
    pmbpw_cmd dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .ext_rdata(ext_rdata), .wp_pin(wp_pin), .strap_high_open(strap_high_open),
        .strap_high_val(strap_high_val), .strap_low_open(strap_low_open),
        .strap_low_val(strap_low_val), .obs_valid(obs_valid), .obs_byte(obs_byte),
        .rsp_valid(rsp_valid), .rsp(rsp), .fwd_valid(fwd_valid), .fwd(fwd),
        .comm_fault(comm_fault), .page_sel(page_sel),
        .channel_config_bits(channel_config_bits), .global_config_bits(global_config_bits));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // seen = {rsp_valid, ack, comm_fault, fwd_valid}, 1 ns after the taking edge
    task automatic xact(input logic [6:0] a, input pmbpw_kind_type k, input logic [7:0] c,
                        input logic [7:0] p, input logic [7:0] dd);
        host.send(a, k, c, p, dd);
        #1;
        seen = {rsp_valid, rsp.ack, comm_fault, fwd_valid};
        rd = rsp.rdata;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] dd);
        xact(7'h4f, PMBPW_WR, c, 8'h00, dd);
    endtask
    function automatic logic allowed(input logic [7:0] lk, input logic wp, input logic [7:0] c);
        logic st;
        st = c inside {[8'h78:8'h7f]};
        if (wp) return c inside {8'h00, 8'h01, 8'he3, 8'hbd, 8'h03} || st;
        case (lk)
            8'h80:   return c inside {8'h10, 8'h00, 8'hbd, 8'h15};
            8'h40:   return c inside {8'h10, 8'h00, 8'hbd, 8'h15, 8'he3, 8'h01, 8'h03} || st;
            8'h20:   return c inside {8'h10, 8'h00, 8'hbd, 8'h15, 8'he3, 8'h01, 8'h03,
                                      8'h02, 8'h21} || st;
            default: return 1'b1;
        endcase
    endfunction
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        void'($urandom(5296));
        {rst_n, wp_pin, strap_high_val, strap_low_val} = '0;
        {strap_high_open, strap_low_open} = 2'b11;
        ext_rdata[0] = 8'($urandom);
        ext_rdata[1] = ~ext_rdata[0];
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (rst_code[i]) begin
            xact(7'h4f, PMBPW_RD, rst_code[i], 8'h00, 8'h00);
            check({seen, rd}, {4'b1100, rst_val[i]});
        end
        d = 8'($urandom);
        d2 = ~d;
        wr(8'h00, 8'h01);
        wr(8'hd0, d);
        check({page_sel, channel_config_bits}, {8'h01, d, 8'h1d});
        wr(8'h21, 8'h00);
        xact(7'h4f, PMBPW_RD, 8'h21, 8'h00, 8'h00);
        check(rd, ext_rdata[1]);
        wr(8'h00, 8'hff);
        wr(8'hd0, d2);
        check(channel_config_bits, {d2, d2});
        wr(8'h21, d);
        check({seen, fwd}, {4'b1101, 8'h21, d, 2'h3, 1'b0});
        xact(7'h4f, PMBPW_RD, 8'h21, 8'h00, 8'h00);
        check(rd, ext_rdata[0]);
        xact(7'h4f, PMBPW_PPW, 8'hd0, 8'h01, d);
        check({seen, page_sel, channel_config_bits}, {4'b1100, 8'hff, d, d2});
        xact(7'h4f, PMBPW_PPR, 8'hd0, 8'h01, 8'h00);
        check({seen, rd, page_sel}, {4'b1100, d, 8'hff});
        glob = 8'($urandom);
        xact(7'h4f, PMBPW_PPW, 8'hd1, 8'h07, glob);
        check({seen, global_config_bits}, {4'b1100, glob});
        xact(7'h4f, PMBPW_PPR, 8'h05, 8'h00, 8'h00);
        check(seen, 4'b1010);
        wr(8'h00, 8'h00);
        foreach (lvl[j]) begin
            @(posedge sys_clk);
            wp_pin <= 1'b0;
            wr(8'h10, lvl[j]);
            @(posedge sys_clk);
            wp_pin <= (j == 4);
            foreach (codes[i]) begin
                dat = (codes[i] == 8'h00) ? 8'h00 : (codes[i] == 8'h10) ? lvl[j] : 8'($urandom);
                wr(codes[i], dat);
                if (allowed(lvl[j], j == 4, codes[i])) begin
                    if (codes[i] == 8'hd1) glob = dat;
                    check(seen, {3'b110, !(codes[i] inside {8'h00, 8'h10, 8'hd1})});
                    if (codes[i] == 8'h78) check(fwd.w1c, 1'b1);
                end else begin
                    check(seen, 4'b1010);
                end
                check(global_config_bits, glob);
            end
            xact(7'h4f, PMBPW_PPW, 8'h02, 8'h00, 8'h1e);
            check(seen[2], allowed(lvl[j], j == 4, 8'h02));
        end
        @(posedge sys_clk);
        wp_pin <= 1'b0;
        wr(8'h10, 8'h00);
        wr(8'he6, 8'h80);
        xact(7'h4f, PMBPW_RD, 8'h00, 8'h00, 8'h00);
        check(seen[3], 1'b0);
        xact(7'h5a, PMBPW_RD, 8'he6, 8'h00, 8'h00);
        check({seen, rd}, {4'b1100, 8'h80});
        xact(7'h5b, PMBPW_WR, 8'hd1, 8'h00, 8'h40);
        xact(7'h5b, PMBPW_WR, 8'he6, 8'h00, 8'h3c);
        check(seen, 4'b1100);
        sv = 4'($urandom);
        @(posedge sys_clk);
        strap_low_open <= 1'b0;
        strap_low_val <= sv;
        xact({3'h3, sv}, PMBPW_RD, 8'he6, 8'h00, 8'h00);
        check({seen, rd}, {4'b1100, 8'h3c});
        @(posedge sys_clk);
        strap_high_open <= 1'b0;
        strap_high_val <= 3'h6;
        xact({3'h6, sv}, PMBPW_RD, 8'hd0, 8'h00, 8'h00);
        check({seen, rd}, {4'b1100, d2});
        xact(7'h5a, PMBPW_PPW, 8'hfa, 8'h00, 8'h30);
        xact(7'h30, PMBPW_RD, 8'hd0, 8'h00, 8'h00);
        check({seen, rd}, {4'b1100, d2});
        host.observe(~d2);
        #1;
        check(comm_fault, 1'b1);
        xact(7'h30, PMBPW_RD, 8'hd0, 8'h00, 8'h00);
        host.observe(d2);
        #1;
        check(comm_fault, 1'b0);
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end
endmodule
